// ==== key_level_sync.sv ====
// key_level_sync: two-stage synchroniser for the keypad input pins
// assumes pins are asynchronous to clk_sys
`timescale 1ns/10ps
module key_level_sync (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic [3:0] pinIn,
  output logic [3:0] pinSync
);
  logic [3:0] meta_q;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      meta_q <= 4'hF;
      pinSync <= 4'hF;
    end
    else if (clkEn)
    begin
      meta_q <= pinIn;
      pinSync <= meta_q;
    end
  end
endmodule

// ==== key_switch_model.sv ====
// key_switch_model: matrix key switches on the four keypad port pins
// assumes port pull-ups hold a pin high while its key is open
`timescale 1ns/10ps
module key_switch_model (
  input wire logic [3:0] pressed,
  output logic [3:0] pins
);
  // closed key pulls its line low, open key floats to the pull-up
  assign pins = ~pressed;
endmodule

// ==== keypad_level_interrupt.sv ====
// keypad_level_interrupt: four-input level interrupt with control/status regs
// assumes the core drives sfr requests on clk_sys and reads rdata next cycle
`timescale 1ns/10ps
module keypad_level_interrupt (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic [3:0] keypadInputs,
  input wire logic keypadGlobalIrqEnable,
  input wire logic powerDown,
  input wire keypad_pkg::sfr_req_t sfrReq,
  output logic [7:0] sfrRdata,
  output logic keypadIrq,
  output logic wakeRequest,
  output logic powerDownWake
);
  logic [7:0] keypadControl_q;
  logic keyPowerdownWakeEnable_q;
  logic [3:0] keyInterruptFlag_q;
  logic [3:0] keyInterruptFlag_d;
  logic [3:0] syncIn;
  logic [3:0] levelSelect;
  logic [3:0] keyInterruptMask;
  logic [3:0] hitSync;
  logic [3:0] hitAsync;
  logic ctrlSel;
  logic statSel;
  logic statRead;
  logic ctrlWrite;
  logic statWrite;
  logic [7:0] statusView;
  logic [7:0] rdataD;
  logic irqD;

  function automatic logic [3:0] levelHit(input logic [3:0] pins, input logic [3:0] sel);
    levelHit = ~(pins ^ sel);
  endfunction

  key_level_sync u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .clkEn(clkEn),
    .pinIn(keypadInputs),
    .pinSync(syncIn)
  );

  assign levelSelect = keypadControl_q[keypad_pkg::LEVEL_SEL_LSB +: keypad_pkg::NUM_KEYS];
  assign keyInterruptMask = keypadControl_q[keypad_pkg::MASK_LSB +: keypad_pkg::NUM_KEYS];
  assign hitSync = levelHit(syncIn, levelSelect);
  assign ctrlSel = sfrReq.addr == keypad_pkg::KEYPAD_CONTROL_ADDR;
  assign statSel = sfrReq.addr == keypad_pkg::KEYPAD_STATUS_ADDR;
  assign statRead = statSel && sfrReq.rd;
  assign ctrlWrite = ctrlSel && sfrReq.wr;
  assign statWrite = statSel && sfrReq.wr;
  // set wins over the read clear, so a held level re-flags at once
  assign keyInterruptFlag_d = (statRead ? 4'h0 : keyInterruptFlag_q) | hitSync;
  assign statusView = {keyPowerdownWakeEnable_q, 3'h0, keyInterruptFlag_q};
  assign rdataD = ctrlSel ? keypadControl_q : (statSel ? statusView : 8'h00);
  assign irqD = keypadGlobalIrqEnable && |(keyInterruptFlag_d & ~keyInterruptMask);

  // unclocked path for power-down: clocks stop, only the pins and regs hold
  assign hitAsync = levelHit(keypadInputs, levelSelect) & ~keyInterruptMask;
  assign powerDownWake = powerDown && keyPowerdownWakeEnable_q && keypadGlobalIrqEnable
    && |hitAsync;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      keypadControl_q <= keypad_pkg::KEYPAD_CONTROL_RESET;
    else if (clkEn && ctrlWrite)
      keypadControl_q <= sfrReq.wdata;
  end

  // only bit 7 of a status write is kept; flags are hardware owned
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      keyPowerdownWakeEnable_q <= keypad_pkg::KEYPAD_STATUS_RESET[keypad_pkg::WAKE_EN_BIT];
    else if (clkEn && statWrite)
      keyPowerdownWakeEnable_q <= sfrReq.wdata[keypad_pkg::WAKE_EN_BIT];
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      keyInterruptFlag_q <= keypad_pkg::KEYPAD_STATUS_RESET[3:0];
    else if (clkEn)
      keyInterruptFlag_q <= keyInterruptFlag_d;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sfrRdata <= 8'h00;
    else if (clkEn)
      sfrRdata <= sfrReq.rd ? rdataD : 8'h00;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      keypadIrq <= 1'h0;
      wakeRequest <= 1'h0;
    end
    else if (clkEn)
    begin
      keypadIrq <= irqD;
      wakeRequest <= irqD; // idle exit
    end
  end

  property p_flag_set;
    @(posedge clk_sys) disable iff (srst)
      clkEn && |hitSync |=> (keyInterruptFlag_q & $past(hitSync)) == $past(hitSync);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set by level");

  property p_read_clear;
    @(posedge clk_sys) disable iff (srst)
      clkEn && statRead && hitSync == 4'h0 |=> keyInterruptFlag_q == 4'h0;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read left flags");

  property p_mask;
    @(posedge clk_sys) disable iff (srst)
      clkEn && (keyInterruptFlag_d & ~keyInterruptMask) == 4'h0 |=> !keypadIrq;
  endproperty
  a_mask: assert property (p_mask) else $error("irq from masked flag");

  property p_irq_on;
    @(posedge clk_sys) disable iff (srst)
      clkEn && keypadGlobalIrqEnable && |(hitSync & ~keyInterruptMask) |=> keypadIrq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");

  property p_global;
    @(posedge clk_sys) disable iff (srst)
      clkEn && !keypadGlobalIrqEnable |=> !keypadIrq;
  endproperty
  a_global: assert property (p_global) else $error("irq while disabled");

  property p_reserved;
    @(posedge clk_sys) disable iff (srst)
      clkEn && statRead |=> sfrRdata[6:4] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_wake;
    @(posedge clk_sys) disable iff (srst)
      !keyPowerdownWakeEnable_q |-> !powerDownWake;
  endproperty
  a_wake: assert property (p_wake) else $error("wake while disabled");

  property p_reset;
    @(posedge clk_sys) srst |=> keypadControl_q == keypad_pkg::KEYPAD_CONTROL_RESET
      && statusView == keypad_pkg::KEYPAD_STATUS_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset values");

  property p_reflag;
    @(posedge clk_sys) disable iff (srst)
      clkEn && statRead && |hitSync |=> keyInterruptFlag_q == $past(hitSync);
  endproperty
  a_reflag: assert property (p_reflag) else $error("held level not re-flagged");

  property p_rdata_idle;
    @(posedge clk_sys) disable iff (srst)
      clkEn && !sfrReq.rd |=> sfrRdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_ctrl_read;
    @(posedge clk_sys) disable iff (srst)
      clkEn && ctrlSel && sfrReq.rd |=> sfrRdata == $past(keypadControl_q);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

  property p_wake_write;
    @(posedge clk_sys) disable iff (srst)
      clkEn && statWrite |=>
        keyPowerdownWakeEnable_q == $past(sfrReq.wdata[keypad_pkg::WAKE_EN_BIT]);
  endproperty
  a_wake_write: assert property (p_wake_write) else $error("wake enable not written");

  property p_flag_no_write;
    @(posedge clk_sys) disable iff (srst)
      clkEn && statWrite && !statRead && hitSync == 4'h0 |=>
        keyInterruptFlag_q == $past(keyInterruptFlag_q);
  endproperty
  a_flag_no_write: assert property (p_flag_no_write) else $error("status write moved flags");

  // clock enable low must hold the control, flag and irq registers still
  property p_freeze;
    @(posedge clk_sys) disable iff (srst)
      !clkEn |=> $stable(keypadControl_q) && $stable(keyInterruptFlag_q) && $stable(keypadIrq);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_two_stage;
    @(posedge clk_sys) disable iff (srst)
      $past(clkEn) && $past(clkEn, 2) && !$past(srst) && !$past(srst, 2) |->
        syncIn == $past(keypadInputs, 2);
  endproperty
  a_two_stage: assert property (p_two_stage) else $error("pin sync depth wrong");

  property p_idle_exit;
    @(posedge clk_sys) disable iff (srst)
      wakeRequest == keypadIrq;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle exit differs from irq");

  c_irq: cover property (@(posedge clk_sys) disable iff (srst) $rose(keypadIrq));
  c_reflag: cover property (@(posedge clk_sys) disable iff (srst) statRead && |hitSync);
  c_pd_blocked: cover property (@(posedge clk_sys) disable iff (srst)
    powerDown && !keyPowerdownWakeEnable_q && |hitAsync);
  c_ack: cover property (@(posedge clk_sys) disable iff (srst) keypadIrq && statRead);
  c_wake: cover property (@(posedge clk_sys) disable iff (srst) powerDownWake);
endmodule

// ==== keypad_level_interrupt_tb_top.sv ====
// keypad_level_interrupt_tb_top: self-checking bench for the keypad interrupt block
// assumes the register port and the switch model in key_switch_model.sv
`timescale 1ns/10ps
module keypad_level_interrupt_tb_top;
  logic clk_sys = 1'h0, srst = 1'h1, clkEn = 1'h1, irqEn = 1'h1, powerDown = 1'h0;
  logic [3:0] pressed = 4'h0;
  logic [3:0] pins;
  logic [7:0] q;
  keypad_pkg::sfr_req_t sfrReq = '0;
  logic [7:0] sfrRdata;
  logic keypadIrq, wakeRequest, powerDownWake;
  int err_count = 0, comparisons = 0, cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  key_switch_model sw_u (.pressed(pressed), .pins(pins));
  keypad_level_interrupt dut_u (.clk_sys(clk_sys), .srst(srst), .clkEn(clkEn),
    .keypadInputs(pins), .keypadGlobalIrqEnable(irqEn), .powerDown(powerDown),
    .sfrReq(sfrReq), .sfrRdata(sfrRdata), .keypadIrq(keypadIrq),
    .wakeRequest(wakeRequest), .powerDownWake(powerDownWake));
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one register access; read data lands one cycle after the strobe
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(negedge clk_sys);
    sfrReq = '{a, w, !w, d};
    @(negedge clk_sys);
    sfrReq = '0;
    q = sfrRdata;
  endtask
  task automatic settle();
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic t_reset();
    acc(8'hA3, 1'h0, 8'h00);
    chk("control", q, 8'h0F);
    acc(8'hA4, 1'h0, 8'h00);
    chk("status", q, 8'h00);
    acc(8'hA5, 1'h0, 8'h00);
    chk("unmapped", q, 8'h00);
  endtask
  task automatic t_level();
    acc(8'hA3, 1'h1, 8'h00);
    pressed = 4'h5;
    settle();
    chk("irq", keypadIrq, 8'h01);
    chk("idle wake", wakeRequest, 8'h01);
    acc(8'hA4, 1'h0, 8'h00);
    chk("flags", q, 8'h05);
    acc(8'hA4, 1'h0, 8'h00);
    chk("held flags", q, 8'h05);
    pressed = 4'h0;
    settle();
    acc(8'hA4, 1'h0, 8'h00);
    acc(8'hA4, 1'h0, 8'h00);
    chk("cleared", q, 8'h00);
    chk("irq off", keypadIrq, 8'h00);
  endtask
  task automatic t_mask();
    acc(8'hA3, 1'h1, 8'hF7);
    pressed = 4'h8;
    settle();
    acc(8'hA4, 1'h0, 8'h00);
    settle();
    acc(8'hA4, 1'h0, 8'h00);
    chk("high flags", q, 8'h07);
    chk("masked irq", keypadIrq, 8'h00);
    pressed = 4'h0;
    settle();
    chk("unmasked irq", keypadIrq, 8'h01);
    irqEn = 1'h0;
    repeat (2) @(negedge clk_sys);
    chk("gated irq", keypadIrq, 8'h00);
  endtask
  task automatic t_wake();
    acc(8'hA3, 1'h1, 8'h07);
    acc(8'hA4, 1'h1, 8'h80);
    acc(8'hA4, 1'h0, 8'h00);
    chk("status wake", q, 8'h8F);
    irqEn = 1'h1;
    powerDown = 1'h1;
    clkEn = 1'h0;
    pressed = 4'h8;
    #1;
    chk("pd wake", powerDownWake, 8'h01);
    pressed = 4'h0;
    #1;
    chk("pd wake gone", powerDownWake, 8'h00);
    @(negedge clk_sys);
    clkEn = 1'h1;
    powerDown = 1'h0;
    acc(8'hA4, 1'h0, 8'h00);
    chk("no key found", q, 8'h80);
    powerDown = 1'h1;
    #1;
    chk("back to sleep", powerDownWake, 8'h00);
    acc(8'hA4, 1'h1, 8'h00);
    pressed = 4'h8;
    #1;
    chk("pd no wake", powerDownWake, 8'h00);
    settle();
    chk("irq in power-down", keypadIrq, 8'h01);
    pressed = 4'h0;
    powerDown = 1'h0;
  endtask
  task automatic t_rereset();
    @(negedge clk_sys);
    srst = 1'h1;
    repeat (2) @(negedge clk_sys);
    srst = 1'h0;
    acc(8'hA3, 1'h0, 8'h00);
    chk("control again", q, 8'h0F);
    acc(8'hA4, 1'h0, 8'h00);
    chk("status again", q, 8'h00);
    chk("irq after reset", keypadIrq, 8'h00);
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (10) @(negedge clk_sys);
    srst = 1'h0;
    t_reset();
    t_level();
    t_mask();
    t_wake();
    t_rereset();
    tally_and_finish();
  end
endmodule

// ==== keypad_pkg.sv ====
// keypad_pkg: constants and types shared by the keypad interrupt block
// assumes an 8-bit special function register port with byte addresses
package keypad_pkg;
  localparam logic [7:0] KEYPAD_CONTROL_ADDR = 8'hA3;
  localparam logic [7:0] KEYPAD_STATUS_ADDR = 8'hA4;
  localparam logic [7:0] KEYPAD_CONTROL_RESET = 8'h0F;
  localparam logic [7:0] KEYPAD_STATUS_RESET = 8'h00;
  localparam int LEVEL_SEL_LSB = 4;
  localparam int MASK_LSB = 0;
  localparam int FLAG_LSB = 0;
  localparam int WAKE_EN_BIT = 7;
  localparam int NUM_KEYS = 4;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_t;
endpackage
